// [logic/dsra_regs.svh]
// Purpose: Constants for the dual serial register access port
// Assumes: Included by bare name from the interface, synchroniser, port and checker files
// Notes: Four-level straps arrive as two-bit codes L=0, R=1, F=2, H=3
`ifndef DSRA_REGS_SVH
`define DSRA_REGS_SVH

// ==========================================================
// Register offsets and fields
`define DSRA_COMM_CTRL_ADDR 8'hff
`define DSRA_COMM_CTRL_RESET 8'h00
`define DSRA_PAGE_EN_BIT 2
`define DSRA_PAGE_CDR 2'h0
`define DSRA_PAGE_DRV 2'h1

// ==========================================================
// Link constants
`define DSRA_FRAME_BITS 17
`define DSRA_SPI_READ 1'b1
`define DSRA_SMB_ADDR_BASE 7'h1d
`define DSRA_SMB_ADDR_RESET 7'h1d
`define DSRA_STRAP_SETTLE 2'h3
`define DSRA_LVL_F 2'h2
`define DSRA_LVL_H 2'h3

// ==========================================================
// Synchroniser pin map and reset levels
`define DSRA_NPINS 11
`define DSRA_PIN_SCL 0
`define DSRA_PIN_SDA 1
`define DSRA_PIN_SCK 2
`define DSRA_PIN_MOSI 3
`define DSRA_PIN_SS 4
`define DSRA_PIN_MODE 5
`define DSRA_PIN_ALO 7
`define DSRA_PIN_AHI 9
`define DSRA_SYNC_RESET 11'h013

`endif

// [logic/dsra_pkg.sv]
// Purpose: Types shared by the register access port modules
// Assumes: Uses nothing from dsra_regs.svh; all codes are written out here
// Notes: Binary state codes written out
package dsra_pkg;
   // Register page currently reached by accesses
   typedef enum logic [1:0] {DSRA_PG_SHARE = 2'b00, DSRA_PG_CDR = 2'b01,
                             DSRA_PG_DRV = 2'b10, DSRA_PG_BAD = 2'b11} dsra_page_t;
   // Two-wire engine states
   typedef enum logic [2:0] {SMB_IDLE = 3'b000, SMB_ADDR = 3'b001, SMB_PTR = 3'b010,
                             SMB_WDATA = 3'b011, SMB_RDATA = 3'b100,
                             SMB_WAIT = 3'b101} dsra_smb_state_t;
endpackage : dsra_pkg

// [logic/dsra_sync_if.sv]
// Purpose: Carries synchronised pin levels and edge pulses
// Assumes: Driven by dsra_pin_sync, read by dsra_port
// Notes: Edge pulses last one clock
`timescale 1ns/100ps
`include "dsra_regs.svh"
interface dsra_sync_if;
   logic [`DSRA_NPINS-1:0] lvl;
   logic [`DSRA_NPINS-1:0] rise;
   logic [`DSRA_NPINS-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface : dsra_sync_if

// [logic/dsra_pin_sync.sv]
// Purpose: Two-flop synchroniser and edge finder for all link pins
// Assumes: Pins are asynchronous to clk_in
// Notes: Edges are taken from the second flop and a third history flop
`timescale 1ns/100ps
`include "dsra_regs.svh"
module dsra_pin_sync (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [`DSRA_NPINS-1:0] pins_in,
   dsra_sync_if.src sync_port
);
   logic [`DSRA_NPINS-1:0] meta_q;
   logic [`DSRA_NPINS-1:0] stable_q;
   logic [`DSRA_NPINS-1:0] hist_q;

   // ==========================================================
   // Synchroniser chain
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta_q <= `DSRA_SYNC_RESET;
         stable_q <= `DSRA_SYNC_RESET;
         hist_q <= `DSRA_SYNC_RESET;
      end
      else
      begin
         meta_q <= pins_in;
         stable_q <= meta_q;
         hist_q <= stable_q;
      end
   end

   // Levels and one-cycle edge pulses
   assign sync_port.lvl = stable_q;
   assign sync_port.rise = stable_q & ~hist_q;
   assign sync_port.fall = ~stable_q & hist_q;
endmodule : dsra_pin_sync

// [logic/dsra_port.sv]
// Purpose: Slave register access port over two-wire or four-wire serial link
// Assumes: Link clock far slower than clk_in (at least 8 clocks per link bit)
// Notes: Register file lives outside; page control register 0xff lives here
//
// What this block does
// - Data falling while clock high starts a two-wire transaction.
// - Data rising while clock high ends a two-wire transaction.
// - Sender releases data in acknowledge slot; low means acknowledge.
// - Write is start, address with direction 0, pointer, data, stop.
// - Read is address, pointer, repeated start, address with direction 1, data.
// - Strap at float or high selects four-wire mode.
// - Four-wire access is a 17-bit frame under low select.
// - Select high ignores serial input and floats serial output.
// - Frame is direction, eight address bits, eight data bits, MSB first.
// - Previous frame shifts out while the new one shifts in.
// - Serial output enables asynchronously when select falls.
// - Write frames execute only at the closing select rise.
// - Frame bits are taken on serial clock rising edges.
// - Leading request bits ignored; dummy frame reads address 0xff.
// - Dummy frame returns requested address and its data.
// - Daisy chain works as one long shift register.
// - Three pages, shared page selected after reset.
// - Writing 100 or 101 to bits 2:0 of 0xff selects pages.
// - Strap low selects two-wire mode.
// - Two four-level straps set the 7-bit address 0x1d to 0x2c.
`timescale 1ns/100ps
`include "dsra_regs.svh"
module dsra_port (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic ss_n_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire logic [1:0] mode_strap_in,
   input wire logic [1:0] slave_address_strap_lo_in,
   input wire logic [1:0] slave_address_strap_hi_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] comm_ctrl_out,
   output dsra_pkg::dsra_page_t page_sel_out,
   output logic spi_mode_out,
   output logic strap_done_out
);
   import dsra_pkg::*;

   // ==========================================================
   // Functions
   function automatic logic [6:0] smb_address(input logic [1:0] lo, input logic [1:0] hi);
      smb_address = `DSRA_SMB_ADDR_BASE + {3'h0, lo, hi};
   endfunction : smb_address

   function automatic dsra_page_t page_decode(input logic [2:0] sel);
      if (!sel[`DSRA_PAGE_EN_BIT])
         page_decode = DSRA_PG_SHARE;
      else if (sel[1:0] == `DSRA_PAGE_CDR)
         page_decode = DSRA_PG_CDR;
      else if (sel[1:0] == `DSRA_PAGE_DRV)
         page_decode = DSRA_PG_DRV;
      else
         page_decode = DSRA_PG_BAD;
   endfunction : page_decode

   // ==========================================================
   // Pin synchronisation
   dsra_sync_if sif();
   logic [`DSRA_NPINS-1:0] pin_vec;

   assign pin_vec = {slave_address_strap_hi_in, slave_address_strap_lo_in, mode_strap_in,
                     ss_n_in, mosi_in, sck_in, sda_in, scl_in};

   dsra_pin_sync u_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .pins_in(pin_vec),
      .sync_port(sif.src)
   );

   // ==========================================================
   // Strap capture after reset release
   logic [1:0] settle_q;
   logic strap_done_q;
   logic spi_mode_q;
   logic [6:0] slave_addr_q;

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         settle_q <= 2'h0;
         strap_done_q <= 1'b0;
         spi_mode_q <= 1'b0;
         slave_addr_q <= `DSRA_SMB_ADDR_RESET;
      end
      else if (!strap_done_q)
      begin
         if (settle_q == `DSRA_STRAP_SETTLE)
         begin
            strap_done_q <= 1'b1;
            spi_mode_q <= (sif.lvl[`DSRA_PIN_MODE+:2] == `DSRA_LVL_F) ||
                          (sif.lvl[`DSRA_PIN_MODE+:2] == `DSRA_LVL_H);
            slave_addr_q <= smb_address(sif.lvl[`DSRA_PIN_ALO+:2],
                                        sif.lvl[`DSRA_PIN_AHI+:2]);
         end
         else
            settle_q <= settle_q + 2'h1;
      end
   end

   // Qualified link events
   logic smb_act;
   logic spi_act;
   logic scl_rise;
   logic scl_fall;
   logic smb_start;
   logic smb_stop;
   logic sck_rise;
   logic sck_fall;
   logic ss_fall;
   logic ss_rise;
   logic frame_on;

   assign smb_act = strap_done_q & ~spi_mode_q;
   assign spi_act = strap_done_q & spi_mode_q;
   assign scl_rise = smb_act & sif.rise[`DSRA_PIN_SCL];
   assign scl_fall = smb_act & sif.fall[`DSRA_PIN_SCL];
   assign smb_start = smb_act & sif.fall[`DSRA_PIN_SDA] & sif.lvl[`DSRA_PIN_SCL];
   assign smb_stop = smb_act & sif.rise[`DSRA_PIN_SDA] & sif.lvl[`DSRA_PIN_SCL];
   assign sck_rise = spi_act & sif.rise[`DSRA_PIN_SCK];
   assign sck_fall = spi_act & sif.fall[`DSRA_PIN_SCK];
   assign ss_fall = spi_act & sif.fall[`DSRA_PIN_SS];
   assign ss_rise = spi_act & sif.rise[`DSRA_PIN_SS];
   assign frame_on = spi_act & ~sif.lvl[`DSRA_PIN_SS];

   // Read result shared by both engines
   logic [7:0] rdata_q;
   logic rd_done_q;

   // ==========================================================
   // Two-wire engine
   dsra_smb_state_t smb_state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] smb_sh_q;
   logic [7:0] smb_ptr_q;
   logic smb_rw_q;
   logic sda_oe_q;
   logic smb_wr_q;
   logic smb_rd_q;

   // Bits sampled on clock rise, data line moved on clock fall
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         smb_state_q <= SMB_IDLE;
         bit_cnt_q <= 4'h0;
         smb_sh_q <= 8'h00;
         smb_ptr_q <= 8'h00;
         smb_rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
         smb_wr_q <= 1'b0;
         smb_rd_q <= 1'b0;
      end
      else
      begin
         smb_wr_q <= 1'b0;
         smb_rd_q <= 1'b0;
         if (smb_start)
         begin
            smb_state_q <= SMB_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end
         else if (smb_stop)
         begin
            smb_state_q <= SMB_IDLE;
            sda_oe_q <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (smb_state_q == SMB_RDATA && bit_cnt_q == 4'h9)
               smb_state_q <= SMB_WAIT;
            else if (smb_state_q != SMB_RDATA && smb_state_q != SMB_IDLE &&
                     smb_state_q != SMB_WAIT && bit_cnt_q < 4'h8)
            begin
               smb_sh_q <= {smb_sh_q[6:0], sif.lvl[`DSRA_PIN_SDA]};
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
         end
         else if (scl_fall)
         begin
            case (smb_state_q)
               SMB_ADDR:
                  if (bit_cnt_q == 4'h8)
                  begin
                     if (smb_sh_q[7:1] == slave_addr_q)
                     begin
                        sda_oe_q <= 1'b1;
                        smb_rw_q <= smb_sh_q[0];
                        smb_rd_q <= smb_sh_q[0];
                        bit_cnt_q <= 4'h9;
                     end
                     else
                        smb_state_q <= SMB_WAIT;
                  end
                  else if (bit_cnt_q == 4'h9)
                  begin
                     bit_cnt_q <= smb_rw_q ? 4'h1 : 4'h0;
                     smb_state_q <= smb_rw_q ? SMB_RDATA : SMB_PTR;
                     sda_oe_q <= smb_rw_q ? ~rdata_q[7] : 1'b0;
                     smb_sh_q <= {rdata_q[6:0], 1'b1};
                  end
               SMB_PTR, SMB_WDATA:
                  if (bit_cnt_q == 4'h8)
                  begin
                     sda_oe_q <= 1'b1;
                     bit_cnt_q <= 4'h9;
                     if (smb_state_q == SMB_PTR)
                        smb_ptr_q <= smb_sh_q;
                     else
                        smb_wr_q <= 1'b1;
                  end
                  else if (bit_cnt_q == 4'h9)
                  begin
                     sda_oe_q <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     smb_state_q <= (smb_state_q == SMB_PTR) ? SMB_WDATA : SMB_WAIT;
                  end
               SMB_RDATA:
                  if (bit_cnt_q < 4'h8)
                  begin
                     sda_oe_q <= ~smb_sh_q[7];
                     smb_sh_q <= {smb_sh_q[6:0], 1'b1};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
                  else if (bit_cnt_q == 4'h8)
                  begin
                     sda_oe_q <= 1'b0;
                     bit_cnt_q <= 4'h9;
                  end
               default:
                  sda_oe_q <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================================
   // Four-wire engine
   logic [`DSRA_FRAME_BITS-1:0] shift_q;
   logic miso_q;
   logic spi_wr_q;
   logic spi_rd_q;
   logic [7:0] spi_addr_q;
   logic [7:0] spi_data_q;

   // Shift register shared by receive and transmit
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         shift_q <= '0;
         miso_q <= 1'b0;
         spi_wr_q <= 1'b0;
         spi_rd_q <= 1'b0;
         spi_addr_q <= 8'h00;
         spi_data_q <= 8'h00;
      end
      else
      begin
         spi_wr_q <= 1'b0;
         spi_rd_q <= 1'b0;
         if (ss_fall)
            miso_q <= shift_q[`DSRA_FRAME_BITS-1];
         else if (frame_on && sck_rise)
            shift_q <= {shift_q[`DSRA_FRAME_BITS-2:0], sif.lvl[`DSRA_PIN_MOSI]};
         else if (frame_on && sck_fall)
            miso_q <= shift_q[`DSRA_FRAME_BITS-1];
         if (ss_rise)
         begin
            spi_addr_q <= shift_q[15:8];
            spi_data_q <= shift_q[7:0];
            if (shift_q[`DSRA_FRAME_BITS-1] == `DSRA_SPI_READ)
               spi_rd_q <= 1'b1;
            else
               spi_wr_q <= 1'b1;
         end
         if (rd_done_q && spi_act)
            shift_q[7:0] <= rdata_q;
      end
   end

   // Output enable set straight from the select pin, cleared by the clock
   logic ss_async_n;
   logic miso_oe_q;

   assign ss_async_n = ss_n_in | ~spi_mode_q;

   always_ff @(posedge clk_in or negedge reset_n_in or negedge ss_async_n)
   begin
      if (!reset_n_in)
         miso_oe_q <= 1'b0;
      else if (!ss_async_n)
         miso_oe_q <= 1'b1;
      else
         miso_oe_q <= 1'b0;
   end

   // ==========================================================
   // Register access
   logic req_wr;
   logic req_rd;
   logic [7:0] req_addr;
   logic [7:0] req_data;

   assign req_wr = smb_wr_q | spi_wr_q;
   assign req_rd = smb_rd_q | spi_rd_q;
   assign req_addr = spi_act ? spi_addr_q : smb_ptr_q;
   assign req_data = spi_act ? spi_data_q : smb_sh_q;

   logic [7:0] comm_q;
   dsra_page_t page_q;
   logic [7:0] reg_addr_q;
   logic [7:0] reg_wdata_q;
   logic reg_wr_q;
   logic reg_rd_q;
   logic rd_pend_q;
   logic rd_local_q;

   // Writes: page control kept here, all else sent out
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         comm_q <= `DSRA_COMM_CTRL_RESET;
         page_q <= DSRA_PG_SHARE;
         reg_wdata_q <= 8'h00;
         reg_wr_q <= 1'b0;
      end
      else
      begin
         reg_wr_q <= 1'b0;
         if (req_wr && req_addr == `DSRA_COMM_CTRL_ADDR)
         begin
            comm_q <= req_data;
            page_q <= page_decode(req_data[2:0]);
         end
         else if (req_wr)
         begin
            reg_wdata_q <= req_data;
            reg_wr_q <= 1'b1;
         end
      end
   end

   // Reads: external data sampled one clock after the strobe
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         reg_addr_q <= 8'h00;
         reg_rd_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_local_q <= 1'b0;
         rd_done_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         reg_rd_q <= 1'b0;
         rd_done_q <= 1'b0;
         rd_pend_q <= req_rd;
         if (req_rd || req_wr)
            reg_addr_q <= req_addr;
         if (req_rd)
         begin
            rd_local_q <= (req_addr == `DSRA_COMM_CTRL_ADDR);
            reg_rd_q <= (req_addr != `DSRA_COMM_CTRL_ADDR);
         end
         if (rd_pend_q)
         begin
            rdata_q <= rd_local_q ? comm_q : reg_rdata_in;
            rd_done_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_q;
   assign miso_out = miso_q;
   assign miso_oe_out = miso_oe_q;
   assign reg_addr_out = reg_addr_q;
   assign reg_wdata_out = reg_wdata_q;
   assign reg_wr_out = reg_wr_q;
   assign reg_rd_out = reg_rd_q;
   assign comm_ctrl_out = comm_q;
   assign page_sel_out = page_q;
   assign spi_mode_out = spi_mode_q;
   assign strap_done_out = strap_done_q;
endmodule : dsra_port

// [dv/dsra_port_assertions.sv]
// Purpose: Concurrent checks on the register access port pins
// Assumes: Bound to dsra_port and sampled on clk_in
// Notes: Pin changes reach the logic three to four clocks late
`timescale 1ns/100ps
`include "dsra_regs.svh"
module dsra_port_chk (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic ss_n_in,
   input wire logic [1:0] mode_strap_in,
   input wire logic sda_oe_out,
   input wire logic miso_oe_out,
   input wire logic reg_wr_out,
   input wire logic reg_rd_out,
   input wire logic [7:0] comm_ctrl_out,
   input wire dsra_pkg::dsra_page_t page_sel_out,
   input wire logic spi_mode_out,
   input wire logic strap_done_out
);
   import dsra_pkg::*;
   // ==========================================================
   // Pin checks
   default clocking chk_cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // Select held high long enough to pass the synchroniser
   sequence s_deselected;
      ss_n_in [*5];
   endsequence
   // Select rose at least three clocks back and is still high
   sequence s_frame_closed;
      ss_n_in && $past(ss_n_in, 3);
   endsequence
   property p_oe_async;
      spi_mode_out && !ss_n_in |-> miso_oe_out;
   endproperty
   a_oe_async: assert property (p_oe_async) else $error("serial out not enabled");
   property p_oe_off;
      s_deselected |-> !miso_oe_out;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("serial out driven while idle");
   property p_wr_closed;
      spi_mode_out && reg_wr_out |-> s_frame_closed;
   endproperty
   a_wr_closed: assert property (p_wr_closed) else $error("write before frame end");
   property p_rd_closed;
      spi_mode_out && reg_rd_out |-> s_frame_closed;
   endproperty
   a_rd_closed: assert property (p_rd_closed) else $error("read before frame end");
   property p_pulse;
      reg_wr_out || reg_rd_out |=> !(reg_wr_out || reg_rd_out);
   endproperty
   a_pulse: assert property (p_pulse) else $error("access strobe too long");
   property p_mode;
      $rose(strap_done_out) |-> ##1 spi_mode_out == mode_strap_in[1];
   endproperty
   a_mode: assert property (p_mode) else $error("link mode differs from strap");
   property p_reset_page;
      $rose(reset_n_in) |-> page_sel_out == DSRA_PG_SHARE && comm_ctrl_out == 8'h00;
   endproperty
   a_reset_page: assert property (p_reset_page) else $error("page not shared after reset");
   property p_page_map;
      page_sel_out == (!comm_ctrl_out[2] ? DSRA_PG_SHARE : comm_ctrl_out[1:0] == 2'h0 ?
         DSRA_PG_CDR : comm_ctrl_out[1:0] == 2'h1 ? DSRA_PG_DRV : DSRA_PG_BAD);
   endproperty
   a_page_map: assert property (p_page_map) else $error("page select mismatch");
   property p_sda_quiet;
      spi_mode_out |-> !sda_oe_out;
   endproperty
   a_sda_quiet: assert property (p_sda_quiet) else $error("data line pulled in spi mode");
   property p_miso_quiet;
      !spi_mode_out |-> !miso_oe_out;
   endproperty
   a_miso_quiet: assert property (p_miso_quiet) else $error("serial out in two-wire mode");
   property p_ack_edge;
      $changed(sda_oe_out) |-> !scl_in;
   endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("data drive moved with clock high");
endmodule : dsra_port_chk

bind dsra_port dsra_port_chk chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
   .ss_n_in(ss_n_in), .mode_strap_in(mode_strap_in), .sda_oe_out(sda_oe_out),
   .miso_oe_out(miso_oe_out), .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out),
   .comm_ctrl_out(comm_ctrl_out), .page_sel_out(page_sel_out), .spi_mode_out(spi_mode_out),
   .strap_done_out(strap_done_out));

// [dv/dsra_host_model.sv]
// Purpose: Host master for the two-wire and four-wire links
// Assumes: Tasks are entered at falling clock edges; delays are whole clocks
// Notes: Link clock period 800 ns; data line is open drain with a pull-up
`timescale 1ns/100ps
module dsra_host_model (
   output logic sck_out = 1'b0,
   output logic mosi_out = 1'b0,
   output logic ss_n_out = 1'b1,
   input wire logic miso_in,
   output logic scl_out = 1'b1,
   output logic sda_pull_out = 1'b0,
   input wire logic sda_in
);
   // ==========================================================
   // Four-wire frames
   // Shifts n bits out MSB first and collects the returned bits
   task automatic spi_frame(input int n, input logic [33:0] tx, output logic [33:0] rx);
      rx = '0;
      ss_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi_out = tx[i];
         #400;
         sck_out = 1'b1;
         rx[i] = miso_in;
         #400;
         sck_out = 1'b0;
      end
      #200;
      ss_n_out = 1'b1;
      mosi_out = ~mosi_out; // Idle input no longer shows the last bit
      #1200;
   endtask : spi_frame
   // One bit: data set while clock low, read back late in clock high
   task automatic smb_bit(input logic b, output logic r);
      #200;
      sda_pull_out = ~b;
      #200;
      scl_out = 1'b1;
      #300;
      r = sda_in;
      #100;
      scl_out = 1'b0;
   endtask : smb_bit
   // Eight bits and the acknowledge slot
   task automatic smb_byte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
         smb_bit(tx[i], rx[i]);
   endtask : smb_byte
   // Start or repeated start
   task automatic smb_start();
      #400;
      sda_pull_out = 1'b0;
      #200;
      scl_out = 1'b1;
      #300;
      sda_pull_out = 1'b1;
      #300;
      scl_out = 1'b0;
   endtask : smb_start
   // Stop, leaving both lines high
   task automatic smb_stop();
      #200;
      sda_pull_out = 1'b1;
      #200;
      scl_out = 1'b1;
      #300;
      sda_pull_out = 1'b0;
      #300;
   endtask : smb_stop
endmodule : dsra_host_model

// [dv/testbench.sv]
// Purpose: Self-checking bench for the register access port
// Assumes: Host model drives the link, bench holds the outside register file
// Notes: Random values from a 16-bit shift register seeded at 39395
`timescale 1ns/100ps
module testbench;
   import dsra_pkg::*;
   // ==========================================================
   // Signals and environment
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] mode = 2'h2;
   logic [1:0] alo = 2'h0;
   logic [1:0] ahi = 2'h0;
   logic sck, mosi, ss_n, miso, miso_oe, scl, pull, sda_o, sda_oe, r_wr, r_rd, spi_mode, done;
   logic [7:0] r_addr, r_wdata, comm;
   logic [7:0] r_rdata = 8'h00;
   logic [7:0] mem [256];
   dsra_page_t page;
   logic [15:0] lfsr = 16'h99e3;
   logic [33:0] rx;
   int n_errors = 0;
   int total_checks = 0;
   wire sda_w = !pull && !(sda_oe && !sda_o);
   wire miso_w = miso_oe ? miso : 1'bz;
   always #50 clk = ~clk;
   dsra_port dut_u (.clk_in(clk), .reset_n_in(rst_n), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .sck_in(sck), .mosi_in(mosi), .ss_n_in(ss_n),
      .miso_out(miso), .miso_oe_out(miso_oe), .mode_strap_in(mode),
      .slave_address_strap_lo_in(alo), .slave_address_strap_hi_in(ahi), .reg_addr_out(r_addr),
      .reg_wdata_out(r_wdata), .reg_wr_out(r_wr), .reg_rd_out(r_rd), .reg_rdata_in(r_rdata),
      .comm_ctrl_out(comm), .page_sel_out(page), .spi_mode_out(spi_mode),
      .strap_done_out(done));
   dsra_host_model host_u (.sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n), .miso_in(miso_w),
      .scl_out(scl), .sda_pull_out(pull), .sda_in(sda_w));
   // Outside register file: writes land, read data follows the address
   always @(negedge clk)
   begin
      if (r_wr === 1'b1)
         mem[r_addr] <= r_wdata;
      r_rdata <= mem[r_addr];
   end
   // ==========================================================
   // Helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   function automatic dsra_page_t page_of(input logic [7:0] v);
      return !v[2] ? DSRA_PG_SHARE : v[1:0] == 2'h0 ? DSRA_PG_CDR :
         v[1:0] == 2'h1 ? DSRA_PG_DRV : DSRA_PG_BAD;
   endfunction : page_of
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      total_checks++;
      if (seen !== want)
      begin
         n_errors++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // Reset with the given mode strap, then wait for strap sampling
   task automatic do_reset(input logic [1:0] m);
      rst_n = 1'b0;
      mode = m;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      for (int n = 0; n < 20 && done !== 1'b1; n++)
         @(negedge clk);
      if (done !== 1'b1)
      begin
         n_errors++;
         conclude();
      end
   endtask : do_reset
   initial
   begin
      #3ms;
      n_errors++;
      conclude();
   end
   // ==========================================================
   // Main sequence
   initial
   begin : main_seq
      logic [7:0] a [4];
      logic [7:0] d [4];
      logic [7:0] pv [5];
      logic [6:0] sa;
      pv = '{8'h04, 8'h06, 8'h07, 8'h00, 8'h05};
      for (int i = 0; i < 256; i++)
         mem[i] = 8'h00;
      lfsr = lfsr_next(lfsr);
      do_reset({1'b1, lfsr[0]});
      check(34'(spi_mode), 34'h1);
      check(34'(page), 34'(DSRA_PG_SHARE));
      check(34'(comm), 34'h0);
      // Random writes; each frame returns the one before it
      for (int i = 0; i < 4; i++)
      begin
         lfsr = lfsr_next(lfsr);
         a[i] = {1'b0, lfsr[6:2], 2'(i)};
         d[i] = lfsr[15:8];
         host_u.spi_frame(17, {17'h0, 1'b0, a[i], d[i]}, rx);
         check(34'(mem[a[i]]), 34'(d[i]));
         check(34'(miso_oe), 34'h0);
         if (i > 0)
            check(rx, {17'h0, 1'b0, a[i-1], d[i-1]});
      end
      // Two-frame reads with a dummy second frame
      for (int i = 0; i < 4; i++)
      begin
         host_u.spi_frame(17, {17'h0, 1'b1, a[i], 8'hff}, rx);
         host_u.spi_frame(17, {17'h0, 17'h1ffff}, rx);
         check(rx, {17'h0, 1'b1, a[i], d[i]});
      end
      // Page control codes, then read the control register back
      foreach (pv[i])
      begin
         host_u.spi_frame(17, {17'h0, 1'b0, 8'hff, pv[i]}, rx);
         check(34'(comm), 34'(pv[i]));
         check(34'(page), 34'(page_of(pv[i])));
      end
      host_u.spi_frame(17, {17'h0, 1'b1, 8'hff, 8'hff}, rx);
      host_u.spi_frame(17, {17'h0, 17'h1ffff}, rx);
      check(rx, {17'h0, 1'b1, 8'hff, 8'h05});
      check(34'(mem[8'hff]), 34'h0);
      // Double-length frame: only the last 17 bits stay
      lfsr = lfsr_next(lfsr);
      host_u.spi_frame(34, {1'b1, lfsr, 1'b0, 8'h80, lfsr[7:0]}, rx);
      check(34'(rx[16:0]), 34'({1'b1, lfsr}));
      check(34'(mem[8'h80]), 34'(lfsr[7:0]));
      // Two-wire mode with random address straps
      lfsr = lfsr_next(lfsr);
      alo = lfsr[1:0];
      ahi = lfsr[3:2];
      do_reset(2'h0);
      check(34'(spi_mode), 34'h0);
      sa = 7'h1d + {3'h0, alo, 2'h0} + {5'h0, ahi};
      host_u.smb_start();
      host_u.smb_byte({sa, 1'b0, 1'b1}, rx[8:0]);
      check(34'(rx[0]), 34'h0);
      host_u.smb_byte({8'h21, 1'b1}, rx[8:0]);
      check(34'(rx[0]), 34'h0);
      host_u.smb_byte({lfsr[15:8], 1'b1}, rx[8:0]);
      check(34'(rx[0]), 34'h0);
      host_u.smb_stop();
      check(34'(mem[8'h21]), 34'(lfsr[15:8]));
      host_u.smb_start();
      host_u.smb_byte({sa, 1'b0, 1'b1}, rx[8:0]);
      host_u.smb_byte({8'h21, 1'b1}, rx[8:0]);
      host_u.smb_start();
      host_u.smb_byte({sa, 1'b1, 1'b1}, rx[8:0]);
      check(34'(rx[0]), 34'h0);
      host_u.smb_byte(9'h1ff, rx[8:0]);
      check(34'(rx[8:1]), 34'(lfsr[15:8]));
      host_u.smb_stop();
      host_u.smb_start();
      host_u.smb_byte({sa ^ 7'h40, 1'b0, 1'b1}, rx[8:0]);
      check(34'(rx[0]), 34'h1);
      host_u.smb_stop();
      conclude();
   end
endmodule : testbench
